// [include/led_gpio_blink_pwm_port_regs.svh]
// Register offsets, field positions, reset values and timing figures of the I/O expander port.
// Assumes inclusion by bare name from the port module and the testbench.
`ifndef LED_GPIO_BLINK_PWM_PORT_REGS_SVH
`define LED_GPIO_BLINK_PWM_PORT_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets.
// ----------------------------------------------------------------------------
`define ADDR_INPUT      8'h00
`define ADDR_PHASE0     8'h01
`define ADDR_PORTS_CFG  8'h03
`define ADDR_PWM_EN     8'h04
`define ADDR_PHASE1     8'h09
`define ADDR_MASTER     8'h0E
`define ADDR_CONFIG     8'h0F
`define ADDR_INTENS_LO  8'h10
`define ADDR_INTENS_1   8'h11
`define ADDR_INTENS_2   8'h12
`define ADDR_INTENS_HI  8'h13

// ----------------------------------------------------------------------------
// Slave address for each strap choice.
// ----------------------------------------------------------------------------
`define SLAVE_GND       7'h20
`define SLAVE_VCC       7'h24
`define SLAVE_SCL       7'h60
`define SLAVE_SDA       7'h64

// ----------------------------------------------------------------------------
// Configuration register fields.
// ----------------------------------------------------------------------------
`define CFG_BLINK_EN    0
`define CFG_FLIP        1
`define CFG_GLOBAL      2
`define CFG_INT_EN      3
`define CFG_AUX_PWM     4
`define CFG_AUX_PH0     5
`define CFG_AUX_PH1     6
`define CFG_BLINK_STAT  7

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define RST_PHASE       8'hFF
`define RST_PORTS_CFG   8'hFF
`define RST_PWM_EN      8'h00
`define RST_MASTER      8'h00
`define RST_CONFIG      7'h60
`define RST_SNAPSHOT    8'hFF

// ----------------------------------------------------------------------------
// Timing: PWM oscillator derived from the core clock.
// ----------------------------------------------------------------------------
`define CLK_HZ          20000000
`define PWM_OSC_HZ      32000
`define PWM_DIV         (`CLK_HZ / `PWM_OSC_HZ)
`define PWM_SLOTS       4'hE
`define PWM_SUB_LAST    4'hF

`endif

// [include/led_gpio_blink_pwm_port_pkg.sv]
// Types shared by the I/O expander port logic.
// Assumes the register header sits beside it on the include path.
package led_gpio_blink_pwm_port_pkg;

	// Decoded strap of the address select input, Gray coded.
	typedef enum logic [1:0]
	{
		ADSEL_GND = 2'h0,
		ADSEL_VCC = 2'h1,
		ADSEL_SCL = 2'h3,
		ADSEL_SDA = 2'h2
	} adsel_e;

	// Byte-wide register value.
	typedef logic [7:0] byte_t;

endpackage

// [hdl/led_gpio_blink_pwm_port.sv]
// Port logic of a serially controlled I/O expander: pins, blink, PWM and interrupt.
// Assumes a serial slave on CLK that issues one-cycle register strobes with full offsets.
//
// Summary of operation
// R1 - Low reset pin aborts serial, restores power-up state.
// R2 - Address select strap decodes to four choices.
// R3 - After reset all eight pins are inputs.
// R4 - Input register reads live level of every pin.
// R5 - Input read captures snapshot, compared continuously.
// R6 - Changed input pulls interrupt low when enabled.
// R7 - Interrupt clears on return or input read.
// R8 - Without interrupt duty, aux pin is ninth output.
// R9 - Blink off: pins follow phase-zero register only.
// R10 - Blink on: pin and flag choose phase.
// R11 - Blink pin level readable in configuration register.
// R12 - PWM timing from nominal 32 kHz oscillator.
// R13 - Per-output PWM enable; others static, glitch-free.
// R14 - PWM globally off stops oscillator, outputs static.
// R15 - Master nibble sets window 1/15 to 15/15.
// R16 - Output nibble scales window 1/16 to 15/16.
// R17 - Global mode: one shared 240-step setting.
// R18 - Standby when serial idle and PWM unused.
// R19 - Blink phase is pin XOR flip flag.
// R20 - Period: fifteen slots of sixteen subslots.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "led_gpio_blink_pwm_port_regs.svh"

module led_gpio_blink_pwm_port
#(
	parameter int PWM_DIV = `PWM_DIV
)
(
	// Clock and reset.
	input  wire logic                                  CLK,
	input  wire logic                                  SRST,
	input  wire logic                                  RST_N,
	// Register port from the serial slave.
	input  wire led_gpio_blink_pwm_port_pkg::byte_t    REG_ADDR,
	input  wire led_gpio_blink_pwm_port_pkg::byte_t    REG_WDATA,
	input  wire logic                                  REG_WR,
	input  wire logic                                  REG_RD,
	output led_gpio_blink_pwm_port_pkg::byte_t         REG_RDATA,
	// Serial slave status and control.
	input  wire logic                                  SERIAL_IDLE,
	output logic                                       SERIAL_ABORT,
	output logic [6:0]                                 SLAVE_ADDR,
	// Serial line levels and address strap.
	input  wire logic                                  SCL_IN,
	input  wire logic                                  SDA_IN,
	input  wire logic                                  ADDRESS_SELECT_INPUT,
	// Open-drain I/O pins.
	input  wire logic [7:0]                            IO_PORT_PINS_IN,
	output logic [7:0]                                 IO_PORT_PINS_OUT,
	output logic [7:0]                                 IO_PORT_PINS_OE,
	// Interrupt or auxiliary open-drain output.
	output logic                                       IRQ_OR_AUX_OUTPUT,
	output logic                                       IRQ_OR_AUX_OE,
	// Blink phase select pin.
	input  wire logic                                  BLINK_PHASE_IN,
	// Power state.
	output logic                                       OSC_RUN,
	output logic                                       STANDBY
);
	import led_gpio_blink_pwm_port_pkg::*;

	initial
	begin
		if (PWM_DIV < 2 || PWM_DIV > 1023)
			$error("PWM_DIV out of the range of the divider.");
	end

	// ------------------------------------------------------------------------
	// Synchronisers for everything that arrives from pins.
	// ------------------------------------------------------------------------
	logic [7:0]  pin_meta_ff;      // First stage of the port pins.
	logic [7:0]  pin_sync_ff;      // Port pin levels in the clock domain.
	logic [4:0]  misc_meta_ff;     // First stage of reset, blink, strap, SCL, SDA.
	logic [4:0]  misc_sync_ff;     // Second stage of the same.
	logic        rst_pin_req;      // Reset pin held low.
	logic        blink_sync;       // Blink pin level.
	logic        ad_sync;          // Address strap level.
	logic        scl_sync;         // Serial clock level.
	logic        sda_sync;         // Serial data level.
	logic        rst_all;          // Either reset source.

	// Two flops per pin; the first stage is read only by the second.
	// No reset here: a reset value would pose as a strap level and spoil the
	// strap history, and the core reset outlasts both stages anyway.
	always_ff @(posedge CLK)
	begin
		pin_meta_ff  <= IO_PORT_PINS_IN;
		pin_sync_ff  <= pin_meta_ff;
		misc_meta_ff <= {RST_N, BLINK_PHASE_IN, ADDRESS_SELECT_INPUT, SCL_IN, SDA_IN};
		misc_sync_ff <= misc_meta_ff;
	end

	assign rst_pin_req = ~misc_sync_ff[4];
	assign blink_sync  = misc_sync_ff[3];
	assign ad_sync     = misc_sync_ff[2];
	assign scl_sync    = misc_sync_ff[1];
	assign sda_sync    = misc_sync_ff[0];
	// The pin reset acts like the core reset on all port state except SERIAL_ABORT, which the pin reset sets and the core reset clears.
	assign rst_all     = SRST | rst_pin_req; // [R1]

	// Tell the serial slave to drop any transfer while the pin reset is low.
	always_ff @(posedge CLK)
	begin
		if (SRST)
			SERIAL_ABORT <= 1'b0;
		else
			SERIAL_ABORT <= rst_pin_req; // [R1]
	end

	// ------------------------------------------------------------------------
	// Address strap decode.
	// ------------------------------------------------------------------------
	logic   seen_hi_ff;            // Strap was seen high since reset.
	logic   seen_lo_ff;            // Strap was seen low since reset.
	logic   diff_scl_ff;           // Strap once differed from the clock line.
	adsel_e adsel;                 // Decoded strap choice.

	// A strap tied to a bus line toggles; one that ever disagrees with SCL is on SDA.
	// Until the bus moves, a line-tied strap reads as a supply choice: harmless,
	// because no address match is needed before the first START.
	always_ff @(posedge CLK)
	begin
		if (rst_all)
		begin
			seen_hi_ff  <= 1'b0;
			seen_lo_ff  <= 1'b0;
			diff_scl_ff <= 1'b0;
		end
		else
		begin
			seen_hi_ff  <= seen_hi_ff | ad_sync;
			seen_lo_ff  <= seen_lo_ff | ~ad_sync;
			diff_scl_ff <= diff_scl_ff | (ad_sync ^ scl_sync);
		end
	end

	always_comb
	begin
		if (seen_hi_ff && seen_lo_ff)
			adsel = diff_scl_ff ? ADSEL_SDA : ADSEL_SCL; // [R2]
		else if (ad_sync)
			adsel = ADSEL_VCC;
		else
			adsel = ADSEL_GND;
	end

	// Slave address: upper and third-lowest bits come from the strap.
	always_ff @(posedge CLK)
	begin
		if (rst_all)
			SLAVE_ADDR <= `SLAVE_GND;
		else
		begin
			unique case (adsel)
				ADSEL_GND: SLAVE_ADDR <= `SLAVE_GND; // [R2]
				ADSEL_VCC: SLAVE_ADDR <= `SLAVE_VCC;
				ADSEL_SCL: SLAVE_ADDR <= `SLAVE_SCL;
				ADSEL_SDA: SLAVE_ADDR <= `SLAVE_SDA;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Register file.
	// ------------------------------------------------------------------------
	byte_t       phase0_ff;        // Phase-zero output levels.
	byte_t       phase1_ff;        // Phase-one output levels.
	byte_t       ports_cfg_ff;     // One bit per pin, 1 = input.
	byte_t       pwm_en_ff;        // One bit per pin, 1 = PWM.
	byte_t       master_ff;        // Master nibble high, aux nibble low.
	logic [6:0]  config_ff;        // Writable configuration bits.
	logic [3:0]  indiv_ff [0:7];   // Per-pin intensity.
	logic [1:0]  pair_idx;         // Intensity register pair index.

	assign pair_idx = REG_ADDR[1:0];

	// Writes from the serial slave; reset leaves every pin an input.
	always_ff @(posedge CLK)
	begin
		if (rst_all)
		begin
			phase0_ff    <= `RST_PHASE;
			phase1_ff    <= `RST_PHASE;
			ports_cfg_ff <= `RST_PORTS_CFG; // [R3]
			pwm_en_ff    <= `RST_PWM_EN;
			master_ff    <= `RST_MASTER;
			config_ff    <= `RST_CONFIG;
			for (int i = 0; i < 8; i++)
				indiv_ff[i] <= 4'h0;
		end
		else if (REG_WR)
		begin
			unique case (REG_ADDR)
				`ADDR_PHASE0:    phase0_ff    <= REG_WDATA;
				`ADDR_PHASE1:    phase1_ff    <= REG_WDATA;
				`ADDR_PORTS_CFG: ports_cfg_ff <= REG_WDATA;
				`ADDR_PWM_EN:    pwm_en_ff    <= REG_WDATA;
				`ADDR_MASTER:    master_ff    <= REG_WDATA;
				`ADDR_CONFIG:    config_ff    <= REG_WDATA[6:0];
				`ADDR_INTENS_LO, `ADDR_INTENS_1, `ADDR_INTENS_2, `ADDR_INTENS_HI:
				begin
					indiv_ff[{pair_idx, 1'b0}] <= REG_WDATA[3:0];
					indiv_ff[{pair_idx, 1'b1}] <= REG_WDATA[7:4];
				end
				default: ; // Writes elsewhere are dropped.
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Input snapshot and read data.
	// ------------------------------------------------------------------------
	byte_t  snap_ff;               // Pin levels taken at the last input read.
	logic   rd_input;              // Read of the input register this cycle.
	logic   change;                // An input pin differs from its snapshot.

	assign rd_input = REG_RD && (REG_ADDR == `ADDR_INPUT);
	assign change   = |((pin_sync_ff ^ snap_ff) & ports_cfg_ff); // [R6]

	// Reset assumes pulled-up idle pins so that no interrupt shows at start.
	always_ff @(posedge CLK)
	begin
		if (rst_all)
			snap_ff <= `RST_SNAPSHOT;
		else if (rd_input)
			snap_ff <= pin_sync_ff; // [R5] [R7]
	end

	// Read data stands one cycle after the strobe; unmapped offsets read zero.
	always_ff @(posedge CLK)
	begin
		if (rst_all)
			REG_RDATA <= 8'h00;
		else if (REG_RD)
		begin
			unique case (REG_ADDR)
				`ADDR_INPUT:     REG_RDATA <= pin_sync_ff; // [R4]
				`ADDR_PHASE0:    REG_RDATA <= phase0_ff;
				`ADDR_PHASE1:    REG_RDATA <= phase1_ff;
				`ADDR_PORTS_CFG: REG_RDATA <= ports_cfg_ff;
				`ADDR_PWM_EN:    REG_RDATA <= pwm_en_ff;
				`ADDR_MASTER:    REG_RDATA <= master_ff;
				`ADDR_CONFIG:    REG_RDATA <= {blink_sync, config_ff}; // [R11]
				`ADDR_INTENS_LO, `ADDR_INTENS_1, `ADDR_INTENS_2, `ADDR_INTENS_HI:
					REG_RDATA <= {indiv_ff[{pair_idx, 1'b1}], indiv_ff[{pair_idx, 1'b0}]};
				default:         REG_RDATA <= 8'h00;
			endcase
		end
		else
			REG_RDATA <= 8'h00;
	end

	// ------------------------------------------------------------------------
	// PWM oscillator and slot counters.
	// ------------------------------------------------------------------------
	logic [9:0]  div_ff;           // Divider for the nominal oscillator.
	logic [3:0]  sub_ff;           // Subslot index, 0 to 15.
	logic [3:0]  slot_ff;          // Master slot index, 0 to 14.
	logic        pwm_on_global;    // Master nibble non-zero: PWM in use.
	logic        osc_tick;         // One oscillator period elapsed.

	assign pwm_on_global = (master_ff[7:4] != 4'h0);
	assign osc_tick      = (div_ff == 10'(PWM_DIV - 1));

	// Counters are held at zero while PWM is unused, which stops the oscillator.
	always_ff @(posedge CLK)
	begin
		if (rst_all || !pwm_on_global)
		begin
			div_ff  <= 10'h000; // [R14]
			sub_ff  <= 4'h0;
			slot_ff <= 4'h0;
		end
		else
		begin
			div_ff <= osc_tick ? 10'h000 : div_ff + 10'h001; // [R12]
			if (osc_tick)
			begin
				sub_ff <= sub_ff + 4'h1;
				if (sub_ff == `PWM_SUB_LAST)
					slot_ff <= (slot_ff == `PWM_SLOTS) ? 4'h0 : slot_ff + 4'h1; // [R20]
			end
		end
	end

	// ------------------------------------------------------------------------
	// Output levels: blink phase selection and PWM gating.
	// ------------------------------------------------------------------------
	logic        phase;            // Active blink phase.
	logic [8:0]  level;            // Static level per output, 1 = released.
	logic [8:0]  pwm_sel;          // Outputs under PWM.
	logic [8:0]  pwm_gate;         // On-time of each PWM output.
	logic [7:0]  pos;              // Position in the 240-step period.

	assign phase   = blink_sync ^ config_ff[`CFG_FLIP]; // [R19] [R10]
	assign pwm_sel = {config_ff[`CFG_AUX_PWM], pwm_en_ff} & {9{pwm_on_global}}; // [R13] [R14]
	assign pos     = {slot_ff, sub_ff};

	// Phase one is used only while blinking is on.
	always_comb
	begin
		if (config_ff[`CFG_BLINK_EN] && phase)
			level = {config_ff[`CFG_AUX_PH1], phase1_ff}; // [R10]
		else
			level = {config_ff[`CFG_AUX_PH0], phase0_ff}; // [R9]
	end

	// Global mode compares the whole period position with one 8-bit setting.
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			if (config_ff[`CFG_GLOBAL])
				pwm_gate[i] = (pos < master_ff); // [R17]
			else
				pwm_gate[i] = (slot_ff < master_ff[7:4]) // [R15]
					&& (sub_ff < indiv_ff[i]); // [R16] [R20]
		end
		// The aux output takes its subslot limit from the low master nibble.
		if (config_ff[`CFG_GLOBAL])
			pwm_gate[8] = (pos < master_ff); // [R17]
		else
			pwm_gate[8] = (slot_ff < master_ff[7:4]) && (sub_ff < master_ff[3:0]); // [R16]
	end

	// Pins sink only when configured as outputs at a low level, gated by PWM.
	always_ff @(posedge CLK)
	begin
		if (rst_all)
		begin
			IO_PORT_PINS_OE  <= 8'h00; // [R3]
			IO_PORT_PINS_OUT <= 8'h00;
		end
		else
		begin
			IO_PORT_PINS_OE  <= ~ports_cfg_ff & ~level[7:0] & (~pwm_sel[7:0] | pwm_gate[7:0]); // [R13]
			IO_PORT_PINS_OUT <= 8'h00;
		end
	end

	// Aux pin: interrupt when enabled, otherwise a ninth output.
	always_ff @(posedge CLK)
	begin
		if (rst_all)
		begin
			IRQ_OR_AUX_OE     <= 1'b0;
			IRQ_OR_AUX_OUTPUT <= 1'b0;
		end
		else
		begin
			if (config_ff[`CFG_INT_EN])
				IRQ_OR_AUX_OE <= change; // [R6] [R7]
			else
				IRQ_OR_AUX_OE <= ~level[8] & (~pwm_sel[8] | pwm_gate[8]); // [R8]
			IRQ_OR_AUX_OUTPUT <= 1'b0;
		end
	end

	// Oscillator and standby flags for the power controller.
	always_ff @(posedge CLK)
	begin
		if (rst_all)
		begin
			OSC_RUN <= 1'b0;
			STANDBY <= 1'b0;
		end
		else
		begin
			OSC_RUN <= pwm_on_global; // [R14]
			STANDBY <= SERIAL_IDLE & ~pwm_on_global; // [R18]
		end
	end

	// ------------------------------------------------------------------------
	// Assertions.
	// ------------------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);

	sequence s_read_input;
		REG_RD && (REG_ADDR == `ADDR_INPUT);
	endsequence

	sequence s_pin_reset;
		rst_pin_req ##1 !rst_pin_req;
	endsequence

	a_pin_reset_state: assert property (s_pin_reset |-> ports_cfg_ff == `RST_PORTS_CFG // [R1]
		&& IO_PORT_PINS_OE == 8'h00 && !IRQ_OR_AUX_OE)
		else $error("Pin reset did not restore power-up state.");
	a_reset_inputs: assert property (rst_all |=> IO_PORT_PINS_OE == 8'h00) // [R3]
		else $error("Pins driven right after reset.");
	a_read_input: assert property (s_read_input |=> REG_RDATA == $past(pin_sync_ff)) // [R4]
		else $error("Input read returned wrong levels.");
	a_snap_capture: assert property (s_read_input ##1 !rst_all |-> snap_ff == $past(pin_sync_ff)) // [R5]
		else $error("Snapshot not taken on input read.");
	a_irq_assert: assert property (config_ff[`CFG_INT_EN] && change && !rst_all // [R6]
		|=> IRQ_OR_AUX_OE)
		else $error("Interrupt not asserted on input change.");
	a_irq_release: assert property (s_read_input ##1 (!rst_all && config_ff[`CFG_INT_EN] // [R7]
		&& $stable(pin_sync_ff)) ##1 !rst_all
		|-> !IRQ_OR_AUX_OE)
		else $error("Interrupt not cleared by input read.");
	a_static_phase0: assert property (!config_ff[`CFG_BLINK_EN] && pwm_en_ff == 8'h00 // [R9]
		&& !rst_all |=> IO_PORT_PINS_OE == (~$past(ports_cfg_ff) & ~$past(phase0_ff)))
		else $error("Static outputs do not follow phase zero.");
	a_blink_phase1: assert property (config_ff[`CFG_BLINK_EN] && (blink_sync ^ config_ff[`CFG_FLIP]) // [R10]
		&& pwm_en_ff == 8'h00 && !rst_all
		|=> IO_PORT_PINS_OE == (~$past(ports_cfg_ff) & ~$past(phase1_ff)))
		else $error("Blink phase one not applied.");
	a_blink_status: assert property (REG_RD && REG_ADDR == `ADDR_CONFIG && !rst_all // [R11]
		|=> REG_RDATA[`CFG_BLINK_STAT] == $past(blink_sync))
		else $error("Blink status bit wrong.");
	a_osc_stopped: assert property (!pwm_on_global |=> div_ff == 10'h000 && slot_ff == 4'h0) // [R14]
		else $error("Oscillator runs while PWM is off.");
	a_slot_range: assert property (slot_ff <= `PWM_SLOTS) // [R20]
		else $error("Master slot index beyond fourteen.");
	a_standby: assert property (!rst_all |=> STANDBY == ($past(SERIAL_IDLE) && !$past(pwm_on_global))) // [R18]
		else $error("Standby flag wrong.");

endmodule

// [testbench/pin_world.sv]
// Behavioural far side of the expander: pull-ups on the port pins, external drivers that
// the bench commands, the two serial bus lines and the strap wiring of the address select input.
// Assumes the port's open-drain enables are high while the port pulls a pin low.
`timescale 1ns/1ps

module pin_world
(
	// Enables from the port and commands from the bench.
	input  wire logic [7:0] port_oe,
	input  wire logic [7:0] ext_low,
	input  wire logic       frame,
	input  wire logic [1:0] strap_sel,
	// Resolved levels seen by the port.
	output logic [7:0]      pin_lvl,
	output logic            scl,
	output logic            sda,
	output logic            strap
);
	// ------------------------------------------------------------------
	// Pins and strap.
	// ------------------------------------------------------------------
	// A released pin is pulled up, so it never holds its last driven level.
	assign pin_lvl = ~(port_oe | ext_low);
	// Strap choice: ground, supply, clock line or data line.
	assign strap = (strap_sel == 2'h0) ? 1'b0 :
		(strap_sel == 2'h1) ? 1'b1 : (strap_sel == 2'h2) ? scl : sda;

	// ------------------------------------------------------------------
	// Bus lines.
	// ------------------------------------------------------------------
	// The clock stands high between frames; inside a frame it has a 400 ns period and an
	// odd start offset, so its edges stay clear of the core clock edges.
	always
	begin
		scl = 1'b1;
		sda = 1'b1;
		wait (frame);
		#37;
		while (frame)
		begin
			#200 scl = 1'b0;
			#100 sda = ~sda;
			#100 scl = 1'b1;
		end
	end
endmodule

// [testbench/tb.sv]
// Self-checking bench of the expander port: register tasks, pin world and sequences of checks.
// Assumes the port package and register header are on the include path.
`timescale 1ns/1ps
`include "led_gpio_blink_pwm_port_regs.svh"

module tb;
	import led_gpio_blink_pwm_port_pkg::*;

	// ------------------------------------------------------------------
	// Signals.
	// ------------------------------------------------------------------
	localparam int DIV    = 4;             // Short PWM tick keeps a period at 960 clocks.
	localparam int PERIOD = 15 * 16 * DIV; // Fifteen slots of sixteen subslots.
	localparam int LIMIT  = 20000;         // Whole run needs well under this.
	logic       clk, srst, rst_n, reg_wr, reg_rd, serial_idle, blink_in, frame;
	logic       abort, aux_oe, osc_run, standby, scl, sda, strap;
	logic [6:0] slave_addr;
	logic [7:0] io_oe, pin_lvl, ext_low;
	logic [1:0] strap_sel;
	byte_t      reg_addr, reg_wdata, reg_rdata;
	int         failures, checked, cycles, n0, n1;

	// ------------------------------------------------------------------
	// Instances.
	// ------------------------------------------------------------------
	led_gpio_blink_pwm_port #(.PWM_DIV(DIV)) led_gpio_blink_pwm_port_inst
	(
		.CLK(clk), .SRST(srst), .RST_N(rst_n),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_RDATA(reg_rdata), .SERIAL_IDLE(serial_idle), .SERIAL_ABORT(abort),
		.SLAVE_ADDR(slave_addr), .SCL_IN(scl), .SDA_IN(sda), .ADDRESS_SELECT_INPUT(strap),
		.IO_PORT_PINS_IN(pin_lvl), .IO_PORT_PINS_OUT(), .IO_PORT_PINS_OE(io_oe),
		.IRQ_OR_AUX_OUTPUT(), .IRQ_OR_AUX_OE(aux_oe), .BLINK_PHASE_IN(blink_in),
		.OSC_RUN(osc_run), .STANDBY(standby)
	);

	pin_world pin_world_inst
	(
		.port_oe(io_oe), .ext_low(ext_low), .frame(frame), .strap_sel(strap_sel),
		.pin_lvl(pin_lvl), .scl(scl), .sda(sda), .strap(strap)
	);

	// ------------------------------------------------------------------
	// Clock, timeout and verdict.
	// ------------------------------------------------------------------
	always #25 clk = ~clk;

	// A hang is cut short here and counted as a mismatch.
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == LIMIT)
		begin
			failures++;
			close_out();
		end
	end

	task automatic close_out();
		if (failures == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Compare and bus tasks.
	// ------------------------------------------------------------------
	task automatic chk_byte(input string what, input byte_t exp, input byte_t got);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_int(input string what, input int exp, input int got);
		checked++;
		if (got != exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	// One-cycle write strobe; lowered at the next edge so calls never collide.
	task automatic wr(input byte_t a, input byte_t d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so they are taken there.
	task automatic rd(input byte_t a, input byte_t exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk_byte("read data", exp, reg_rdata);
	endtask

	// Room for register, output and pin synchroniser delays.
	task automatic settle();
		repeat (6) @(posedge clk);
		#1;
	endtask

	// Counts cycles with pin 0 and pin 1 pulled low over one full PWM period.
	task automatic measure();
		n0 = 0;
		n1 = 0;
		repeat (PERIOD)
		begin
			@(posedge clk);
			#1;
			if (io_oe[0] === 1'b1) n0++;
			if (io_oe[1] === 1'b1) n1++;
		end
	endtask

	// Rewires the strap, resets, runs an optional bus frame, then checks the address.
	// The strap history counts from reset, so each wiring gets a reset of its own.
	task automatic strap_frame(input logic [1:0] sel, input logic run, input byte_t exp);
		strap_sel <= sel;
		repeat (3) @(posedge clk);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		serial_idle <= ~run;
		frame <= run;
		repeat (200) @(posedge clk);
		#1;
		chk_byte("standby", {7'h00, ~run}, {7'h00, standby});
		frame <= 1'b0;
		serial_idle <= 1'b1;
		settle();
		chk_byte("slave address", exp, {1'b0, slave_addr});
	endtask

	// ------------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------------
	initial
	begin
		clk = 0; srst = 1; rst_n = 1; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
		serial_idle = 1; blink_in = 0; frame = 0; ext_low = 0; strap_sel = 0;
		failures = 0; checked = 0; cycles = 0;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		settle();
		// Power-up state: all pins released inputs, oscillator off, standby.
		chk_byte("pin enables", 8'h00, io_oe);
		chk_byte("aux enable", 8'h00, {7'h00, aux_oe});
		chk_byte("standby", 8'h01, {7'h00, standby});
		chk_byte("oscillator", 8'h00, {7'h00, osc_run});
		chk_byte("slave address", 8'h20, {1'b0, slave_addr});
		rd(`ADDR_CONFIG, 8'h60);
		rd(`ADDR_INPUT, 8'hFF);
		rd(8'h05, 8'h00);
		wr(`ADDR_INPUT, 8'h00);
		rd(`ADDR_INPUT, 8'hFF);
		// Static outputs; phase one must not show while blinking is off.
		wr(`ADDR_PORTS_CFG, 8'h00);
		wr(`ADDR_PHASE1, 8'h3C);
		wr(`ADDR_PHASE0, 8'hA5);
		settle();
		chk_byte("pin enables", 8'h5A, io_oe);
		rd(`ADDR_INPUT, 8'hA5);
		// Blinking: pin and flip flag select the phase together.
		wr(`ADDR_CONFIG, 8'h01);
		settle();
		chk_byte("pin enables", 8'h5A, io_oe);
		blink_in <= 1'b1;
		settle();
		chk_byte("pin enables", 8'hC3, io_oe);
		chk_byte("aux enable", 8'h01, {7'h00, aux_oe});
		rd(`ADDR_CONFIG, 8'h81);
		wr(`ADDR_CONFIG, 8'h23);
		settle();
		chk_byte("pin enables", 8'h5A, io_oe);
		chk_byte("aux enable", 8'h00, {7'h00, aux_oe});
		// Transition detect on the four low pins, the high ones being outputs.
		blink_in <= 1'b0;
		wr(`ADDR_PHASE0, 8'hF0);
		wr(`ADDR_PORTS_CFG, 8'h0F);
		wr(`ADDR_CONFIG, 8'h08);
		settle();
		rd(`ADDR_INPUT, 8'hFF);
		settle();
		chk_byte("aux enable", 8'h00, {7'h00, aux_oe});
		ext_low <= 8'h01;
		settle();
		chk_byte("aux enable", 8'h01, {7'h00, aux_oe});
		ext_low <= 8'h00;
		settle();
		chk_byte("aux enable", 8'h00, {7'h00, aux_oe});
		ext_low <= 8'h02;
		settle();
		chk_byte("aux enable", 8'h01, {7'h00, aux_oe});
		rd(`ADDR_INPUT, 8'hFD);
		@(posedge clk);
		#1;
		chk_byte("aux enable", 8'h00, {7'h00, aux_oe});
		wr(`ADDR_PHASE0, 8'hE0);
		settle();
		chk_byte("aux enable", 8'h00, {7'h00, aux_oe});
		ext_low <= 8'h00;
		settle();
		rd(`ADDR_INPUT, 8'hEF);
		// PWM on pin 0 only; pin 1 stays a static low output.
		wr(`ADDR_CONFIG, 8'h00);
		wr(`ADDR_PORTS_CFG, 8'h00);
		wr(`ADDR_PHASE0, 8'h00);
		wr(`ADDR_PWM_EN, 8'h01);
		wr(`ADDR_INTENS_LO, 8'h05);
		wr(`ADDR_MASTER, 8'h30);
		settle();
		chk_byte("oscillator", 8'h01, {7'h00, osc_run});
		chk_byte("standby", 8'h00, {7'h00, standby});
		measure();
		chk_int("pwm on cycles", 3 * 5 * DIV, n0);
		chk_int("static cycles", PERIOD, n1);
		wr(`ADDR_CONFIG, 8'h04);
		wr(`ADDR_MASTER, 8'h25);
		settle();
		measure();
		chk_int("global cycles", 37 * DIV, n0);
		wr(`ADDR_MASTER, 8'h00);
		settle();
		measure();
		chk_int("pwm off cycles", PERIOD, n0);
		chk_byte("oscillator", 8'h00, {7'h00, osc_run});
		// Strap decode: supply, then clock line, then data line.
		strap_frame(2'h1, 1'b0, 8'h24);
		strap_frame(2'h2, 1'b1, 8'h60);
		strap_frame(2'h3, 1'b1, 8'h64);
		// Reset pin aborts the serial side and restores power-up state.
		wr(`ADDR_PORTS_CFG, 8'h00);
		wr(`ADDR_PHASE0, 8'h00);
		settle();
		chk_byte("pin enables", 8'hFF, io_oe);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk_byte("serial abort", 8'h01, {7'h00, abort});
		settle();
		chk_byte("pin enables", 8'h00, io_oe);
		rst_n <= 1'b1;
		settle();
		rd(`ADDR_PHASE0, 8'hFF);
		rd(`ADDR_PORTS_CFG, 8'hFF);
		close_out();
	end
endmodule
